// ===== flash_reset_defines.svh
// constants for the pin reset controller of the serial flash
`ifndef FLASH_RESET_DEFINES_SVH
`define FLASH_RESET_DEFINES_SVH
`define SYS_CLK_MHZ           125
`define QUAD_ENABLE_BIT       1
`define RESET_FEATURE_BIT     5
`define SELECT_HIGH_READ_NS   10
`define SELECT_HIGH_RSTQ_NS   20
`define SELECT_HIGH_PE_NS     50
`define RESET_PULSE_NS        200
`define RESET_HOLD_US         35
`define RESET_SETUP_NS        50
`define RESET_HIGH_SEL_NS     50
`define PD_ENTRY_US           3
`define PD_RELEASE_US         30
`define POWER_UP_US           300
`define NS_CEIL(t)  (((t) * `SYS_CLK_MHZ + 999) / 1000)
`define NS_FLOOR(t) (((t) * `SYS_CLK_MHZ) / 1000)
`define US_FLOOR(t) ((t) * `SYS_CLK_MHZ)
`endif

// ===== flash_reset_pkg.sv
// types shared by the pin reset controller
package flash_reset_pkg;
   typedef enum logic [2:0] {
      ST_POWER_UP = 3'b000,
      ST_STANDBY  = 3'b001,
      ST_RESET    = 3'b011,
      ST_HOLD     = 3'b010,
      ST_PD_ENTER = 3'b110,
      ST_PD       = 3'b111,
      ST_PD_EXIT  = 3'b101
   } ctrl_state_t;
   typedef struct packed {
      logic soft_reset;
      logic pd_enter;
      logic pd_release;
      logic quad_data_out;
      logic prog_erase;
   } cmd_t;
   typedef struct packed {
      logic quad_enable;
      logic reset_feature;
   } config_t;
endpackage

// ===== link_sync.sv
// two-flop synchroniser for a single level
`timescale 1ns/1ps
`default_nettype none
module link_sync #(
   parameter logic RESET_VALUE = 1'b0
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic d,
   output logic      q
);
   logic first;
   // first stage read only by second
   always_ff @(posedge clk) begin
      if (rst) begin
         first <= RESET_VALUE;
         q     <= RESET_VALUE;
      end else begin
         first <= d;
         q     <= first;
      end
   end
endmodule
`default_nettype wire

// ===== interval_timer.sv
// down counter reporting when a loaded interval has run out
`timescale 1ns/1ps
`default_nettype none
module interval_timer #(
   parameter int WIDTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] count,
   output logic                  done
);
   logic [WIDTH-1:0] remain;
   // load restarts, otherwise count down to zero
   always_ff @(posedge clk) begin
      if (rst) begin
         remain <= '0;
      end else if (load) begin
         remain <= count;
      end else if (remain != '0) begin
         remain <= remain - 1'b1;
      end
   end
   assign done = (remain == '0) && !load;
endmodule
`default_nettype wire

// ===== flash_pin_reset_control.sv
// warm reset, select-high and power-down control of the serial flash
`timescale 1ns/1ps
`default_nettype none
`include "flash_reset_defines.svh"
module flash_pin_reset_control #(
   parameter int POWER_UP_CYCLES = `US_FLOOR(`POWER_UP_US),
   parameter int HOLD_CYCLES     = `US_FLOOR(`RESET_HOLD_US),
   parameter int PD_ENTRY_CYCLES = `US_FLOOR(`PD_ENTRY_US),
   parameter int PD_EXIT_CYCLES  = `US_FLOOR(`PD_RELEASE_US)
) (
   input  wire logic                     SYS_CLK,
   input  wire logic                     SRST,
   input  wire logic                     LINK_CLK,
   input  wire logic                     CS_N,
   input  wire logic                     IO3_IN,
   input  wire logic [7:0]               CFG_ONE,
   input  wire logic [7:0]               CFG_TWO,
   input  wire logic                     POR_OK,
   input  wire flash_reset_pkg::cmd_t    CMD,
   output logic                          IO3_OUT,
   output logic                          IO3_OE,
   output logic                          OUT_DISABLE,
   output logic                          ABORT,
   output logic                          REG_RELOAD,
   output logic                          FULL_POR,
   output logic                          CMD_BLOCK,
   output logic                          SELECT_ALLOWED,
   output logic                          IN_POWERDOWN,
   output flash_reset_pkg::ctrl_state_t  STATE
);
   import flash_reset_pkg::*;

   localparam int TW = 24;
   localparam logic [TW-1:0] PULSE_CYC  = TW'(`NS_CEIL(`RESET_PULSE_NS));
   localparam logic [TW-1:0] SETUP_CYC  = TW'(`NS_CEIL(`RESET_SETUP_NS));
   localparam logic [TW-1:0] RH_CYC     = TW'(`NS_CEIL(`RESET_HIGH_SEL_NS));
   localparam logic [TW-1:0] SEL_RD_CYC = TW'(`NS_CEIL(`SELECT_HIGH_READ_NS));
   localparam logic [TW-1:0] SEL_RQ_CYC = TW'(`NS_CEIL(`SELECT_HIGH_RSTQ_NS));
   localparam logic [TW-1:0] SEL_PE_CYC = TW'(`NS_CEIL(`SELECT_HIGH_PE_NS));

   // link-domain command capture, handed over by toggle
   logic       cmd_tog_link = 1'b0; // link flops start from their power-up value
   cmd_t       cmd_hold_link = '0;
   logic       cmd_tog_sys;
   logic       cmd_tog_seen;
   cmd_t       cmd_sys;
   logic       cmd_event;
   always_ff @(posedge LINK_CLK) begin
      if (CMD != '0) begin
         cmd_hold_link <= CMD;
         cmd_tog_link  <= ~cmd_tog_link;
      end
   end
   link_sync u_cmd_sync (
      .clk (SYS_CLK),
      .rst (SRST),
      .d   (cmd_tog_link),
      .q   (cmd_tog_sys)
   );
   assign cmd_event = cmd_tog_sys != cmd_tog_seen;
   // held command is stable once the toggle has crossed
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         cmd_tog_seen <= 1'b0;
         cmd_sys      <= '0;
      end else begin
         cmd_tog_seen <= cmd_tog_sys;
         cmd_sys      <= cmd_event ? cmd_hold_link : '0;
      end
   end

   // pins synchronised before any logic reads them
   logic cs_n_s;
   logic io3_s;
   link_sync #(.RESET_VALUE(1'b1)) u_cs_sync (
      .clk (SYS_CLK),
      .rst (SRST),
      .d   (CS_N),
      .q   (cs_n_s)
   );
   link_sync #(.RESET_VALUE(1'b1)) u_io3_sync (
      .clk (SYS_CLK),
      .rst (SRST),
      .d   (IO3_IN),
      .q   (io3_s)
   );

   // configuration bits
   logic quad_on;
   logic long_select;
   assign quad_on     = CFG_ONE[`QUAD_ENABLE_BIT];
   assign long_select = quad_on && CFG_TWO[`RESET_FEATURE_BIT];

   // remember last command kind to size the select-high interval
   logic last_pe;
   logic last_quad_out;
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         last_pe       <= 1'b0;
         last_quad_out <= 1'b0;
      end else if (cmd_sys != '0) begin
         last_pe       <= cmd_sys.prog_erase;
         last_quad_out <= cmd_sys.quad_data_out && quad_on;
      end
   end

   // select-high interval timer, restarted on select rising
   logic            cs_prev;
   logic            cs_rise;
   logic            sel_done;
   logic [TW-1:0]   sel_count;
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         cs_prev <= 1'b1;
      end else begin
         cs_prev <= cs_n_s;
      end
   end
   assign cs_rise = cs_n_s && !cs_prev;
   always_comb begin
      if (last_pe) begin
         sel_count = SEL_PE_CYC;
      end else if (long_select) begin
         sel_count = SEL_RQ_CYC;
      end else begin
         sel_count = SEL_RD_CYC;
      end
   end
   interval_timer #(.WIDTH(TW)) u_sel_timer (
      .clk   (SYS_CLK),
      .rst   (SRST),
      .load  (cs_rise),
      .count (sel_count),
      .done  (sel_done)
   );

   // pin acts as reset only outside quad use or after select-high interval
   logic pin_is_reset;
   assign pin_is_reset = !quad_on || (cs_n_s && sel_done && !cs_rise);

   // low pulse width qualification and high-setup tracking
   ctrl_state_t   state;
   ctrl_state_t   next_state;
   logic [TW-1:0] low_count;
   logic [TW-1:0] high_count;
   logic          pulse_valid;
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         low_count  <= '0;
         high_count <= '0;
      end else begin
         if (pin_is_reset && !io3_s) begin
            if (low_count != PULSE_CYC) begin
               low_count <= low_count + 1'b1;
            end
         end else begin
            low_count <= '0;
         end
         if (io3_s) begin
            if (high_count != SETUP_CYC) begin
               high_count <= high_count + 1'b1;
            end
         end else if (state != ST_POWER_UP) begin
            high_count <= '0;
         end
      end
   end
   assign pulse_valid = (low_count == PULSE_CYC);

   // main sequencing state and interval counter
   logic [TW-1:0] wait_count;
   logic          wait_over;
   logic          use_full_por;
   logic          armed;
   assign wait_over = (wait_count == '0);

   always_comb begin
      next_state = state;
      case (state)
         ST_POWER_UP: begin
            if (wait_over && io3_s) begin
               next_state = ST_STANDBY;
            end
         end
         ST_STANDBY: begin
            if (pulse_valid && armed) begin
               next_state = ST_RESET;
            end else if (cmd_sys.pd_enter) begin
               next_state = ST_PD_ENTER;
            end
         end
         ST_RESET: begin
            next_state = ST_HOLD;
         end
         ST_HOLD: begin
            if (wait_over) begin
               next_state = use_full_por ? ST_POWER_UP : ST_STANDBY;
            end
         end
         ST_PD_ENTER: begin
            if (wait_over) begin
               next_state = ST_PD;
            end
         end
         ST_PD: begin
            if (cmd_sys.pd_release) begin
               next_state = ST_PD_EXIT;
            end
         end
         ST_PD_EXIT: begin
            if (wait_over) begin
               next_state = ST_STANDBY;
            end
         end
         default: begin
            next_state = ST_POWER_UP;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         state <= ST_POWER_UP;
      end else begin
         state <= next_state;
      end
   end

   // arming needs pin high for setup time after hold; lows during power-up do not restart the setup count
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         armed <= 1'b0;
      end else if (state == ST_POWER_UP || state == ST_HOLD) begin
         armed <= 1'b0;
      end else if (high_count == SETUP_CYC) begin
         armed <= 1'b1;
      end
   end

   // choose warm or full power-on reset
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         use_full_por <= 1'b0;
      end else if (state == ST_STANDBY && next_state == ST_RESET) begin
         use_full_por <= !POR_OK;
      end
   end

   // interval counter loaded on each entry
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         wait_count <= TW'(POWER_UP_CYCLES);
      end else if (state == ST_RESET) begin
         wait_count <= use_full_por ? '0
                                    : TW'(HOLD_CYCLES) - PULSE_CYC;
      end else if (state == ST_STANDBY && next_state == ST_PD_ENTER) begin
         wait_count <= TW'(PD_ENTRY_CYCLES);
      end else if (state == ST_PD && next_state == ST_PD_EXIT) begin
         wait_count <= TW'(PD_EXIT_CYCLES);
      end else if (state == ST_HOLD && next_state == ST_POWER_UP) begin
         wait_count <= TW'(POWER_UP_CYCLES);
      end else if (!wait_over) begin
         wait_count <= wait_count - 1'b1;
      end
   end

   // select permission after pin returns high
   logic [TW-1:0] rh_count;
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         rh_count <= '0;
      end else if (!io3_s) begin
         rh_count <= '0;
      end else if (rh_count != RH_CYC) begin
         rh_count <= rh_count + 1'b1;
      end
   end

   // registered outputs
   logic busy;
   assign busy = (state == ST_POWER_UP) || (state == ST_RESET) || (state == ST_HOLD);

   // soft reset only accepted in standby, never while powered down
   logic soft_ok;
   assign soft_ok = cmd_sys.soft_reset && (state == ST_STANDBY);

   // one-cycle answers to a taken reset or a reset command
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         ABORT      <= 1'b0;
         REG_RELOAD <= 1'b0;
         FULL_POR   <= 1'b0;
      end else begin
         ABORT      <= (state == ST_RESET);
         REG_RELOAD <= (state == ST_RESET && !use_full_por) || soft_ok;
         FULL_POR   <= (state == ST_RESET && use_full_por);
      end
   end

   // tristate and command gating while busy or powered down
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         OUT_DISABLE <= 1'b1;
         CMD_BLOCK   <= 1'b1;
      end else begin
         OUT_DISABLE <= busy || (state == ST_PD);
         CMD_BLOCK   <= busy || (state == ST_PD_ENTER) || (state == ST_PD);
      end
   end

   // host select permission
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         SELECT_ALLOWED <= 1'b0;
      end else begin
         SELECT_ALLOWED <= !busy && (rh_count == RH_CYC);
      end
   end

   // power-down flag and state copy
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         IN_POWERDOWN <= 1'b0;
         STATE        <= ST_POWER_UP;
      end else begin
         IN_POWERDOWN <= (state == ST_PD);
         STATE        <= next_state;
      end
   end

   // drive IO3 high through select-high interval after quad data-out
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         IO3_OUT <= 1'b0;
         IO3_OE  <= 1'b0;
      end else begin
         IO3_OUT <= 1'b1;
         IO3_OE  <= !busy && last_quad_out && cs_n_s && (cs_rise || !sel_done);
      end
   end
endmodule
`default_nettype wire

// ===== flash_reset_monitor.sv
// port assertions for the pin reset controller
`timescale 1ns/1ps
`default_nettype none
module flash_reset_monitor #(
   parameter int HOLD_CYCLES     = 4375,
   parameter int PD_ENTRY_CYCLES = 375,
   parameter int PD_EXIT_CYCLES  = 3750
) (
   input wire logic                        SYS_CLK,
   input wire logic                        SRST,
   input wire logic                        CS_N,
   input wire logic [7:0]                  CFG_ONE,
   input wire logic                        IO3_OUT,
   input wire logic                        IO3_OE,
   input wire logic                        OUT_DISABLE,
   input wire logic                        ABORT,
   input wire logic                        REG_RELOAD,
   input wire logic                        FULL_POR,
   input wire logic                        CMD_BLOCK,
   input wire logic                        SELECT_ALLOWED,
   input wire logic                        IN_POWERDOWN,
   input wire flash_reset_pkg::ctrl_state_t STATE
);
   import flash_reset_pkg::*;
   localparam int PDE_MAX = PD_ENTRY_CYCLES + 8;
   localparam int PDX_MAX = PD_EXIT_CYCLES + 8;
   int   cs_low;
   int   blk;
   int   pdx;
   logic warm;
   // cycles with select low in quad mode
   always_ff @(posedge SYS_CLK) begin
      if (SRST || CS_N || !CFG_ONE[1]) cs_low <= 0;
      else cs_low <= cs_low + 1;
   end
   // block length since a warm reset was taken
   always_ff @(posedge SYS_CLK) begin
      if (SRST || (ABORT && REG_RELOAD)) blk <= 0;
      else if (CMD_BLOCK) blk <= blk + 1;
   end
   // cycles spent leaving power-down
   always_ff @(posedge SYS_CLK) begin
      if (SRST || STATE != ST_PD_EXIT) pdx <= 0;
      else pdx <= pdx + 1;
   end
   // marks a running warm reset hold
   always_ff @(posedge SYS_CLK) begin
      if (SRST || FULL_POR) warm <= 1'b0;
      else if (ABORT && REG_RELOAD) warm <= 1'b1;
      else if (!CMD_BLOCK) warm <= 1'b0;
   end
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SRST);
   sequence s_warm_taken;
      ABORT && REG_RELOAD;
   endsequence
   sequence s_pd_start;
      $rose(STATE == ST_PD_ENTER);
   endsequence
   sequence s_pd_leave;
      $rose(STATE == ST_PD_EXIT);
   endsequence
   chk_abort_tristate: assert property (s_warm_taken |-> OUT_DISABLE && CMD_BLOCK)
      else $error("abort without tristate and block");
   chk_abort_single: assert property (ABORT |=> !ABORT)
      else $error("abort longer than one cycle");
   chk_taken_answer: assert property (STATE == ST_RESET |-> ##[0:4] (ABORT || FULL_POR))
      else $error("reset state without answer");
   chk_hold_select: assert property (STATE == ST_HOLD |-> !SELECT_ALLOWED)
      else $error("select allowed during hold");
   chk_hold_span: assert property (warm && $fell(CMD_BLOCK) |-> blk >= HOLD_CYCLES - 40 && blk <= HOLD_CYCLES)
      else $error("hold period wrong length");
   chk_quad_ignore: assert property (cs_low > 32 |-> !ABORT && !FULL_POR)
      else $error("reset taken while select low in quad mode");
   chk_powerup_quiet: assert property (STATE == ST_POWER_UP |-> !REG_RELOAD)
      else $error("reload during power-up");
   chk_pd_entry: assert property (s_pd_start |-> ##[1:PDE_MAX] IN_POWERDOWN)
      else $error("power-down entry late");
   chk_pd_release: assert property (STATE == ST_PD_EXIT |-> pdx < PDX_MAX)
      else $error("power-down release late");
   chk_pd_flag_drop: assert property (s_pd_leave |-> ##1 !IN_POWERDOWN)
      else $error("power-down flag kept while leaving");
   chk_pd_deaf: assert property (IN_POWERDOWN |-> !REG_RELOAD)
      else $error("command taken in power-down");
   chk_io3_high: assert property (IO3_OE |-> IO3_OUT)
      else $error("device drives pin low");
endmodule
bind flash_pin_reset_control flash_reset_monitor #(
   .HOLD_CYCLES(HOLD_CYCLES), .PD_ENTRY_CYCLES(PD_ENTRY_CYCLES), .PD_EXIT_CYCLES(PD_EXIT_CYCLES)
) i_mon (
   .SYS_CLK(SYS_CLK), .SRST(SRST), .CS_N(CS_N), .CFG_ONE(CFG_ONE), .IO3_OUT(IO3_OUT), .IO3_OE(IO3_OE),
   .OUT_DISABLE(OUT_DISABLE), .ABORT(ABORT), .REG_RELOAD(REG_RELOAD), .FULL_POR(FULL_POR),
   .CMD_BLOCK(CMD_BLOCK), .SELECT_ALLOWED(SELECT_ALLOWED), .IN_POWERDOWN(IN_POWERDOWN), .STATE(STATE)
);
`default_nettype wire

// ===== spi_host_model.sv
// host controller model: select, reset pin and link commands
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   input  wire logic             clk,
   output logic                  link_clk,
   output logic                  cs_n,
   output logic                  io3_oe,
   output logic                  io3,
   output flash_reset_pkg::cmd_t cmd
);
   import flash_reset_pkg::*;
   logic link_run;
   logic link_raw;
   // link clock stands still outside frames
   initial begin
      link_raw = 1'b0;
      link_run = 1'b0;
      cs_n = 1'b1;
      io3_oe = 1'b0;
      io3 = 1'b1;
      cmd = '0;
      #1.3;
      forever #3 link_raw = ~link_raw;
   end
   assign link_clk = link_raw & link_run;
   // pin low for n cycles, then driven high before release
   task automatic pin_pulse(input int n);
      io3_oe = 1'b1;
      io3 = 1'b0;
      repeat (n) @(posedge clk);
      #1 io3 = 1'b1;
      repeat (2) @(posedge clk);
      #1 io3_oe = 1'b0;
   endtask
   // select only moved by the bench outside hold periods
   task automatic set_cs(input logic v);
      cs_n = v;
   endtask
   // one link edge per command frame, keeps the link rate low
   task automatic send_cmd(input cmd_t c);
      @(negedge link_raw);
      cmd      = c;
      link_run = 1'b1;
      @(negedge link_raw);
      link_run = 1'b0;
      cmd      = '0;
   endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
// self-checking bench of the pin reset controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import flash_reset_pkg::*;
   localparam int HOLD = 200;
   logic        sys_clk, srst, link_clk, cs_n, io3_in, por_ok, host_oe, host_io3;
   logic        io3_out, io3_oe, out_dis, abort, reload, full_por, cmd_block, sel_ok, in_pd;
   logic [7:0]  cfg_one, cfg_two;
   logic [15:0] rnd;
   cmd_t        cmd;
   ctrl_state_t state;
   int          n_errors, checks_done, n_abort, n_reload, n_por, e_abort, e_reload, e_por, oe_seen, k;
   // pin level from both drivers, pull-up when released
   assign io3_in = io3_oe ? io3_out : (host_oe ? host_io3 : 1'b1);
   spi_host_model i_host (.clk(sys_clk), .link_clk(link_clk), .cs_n(cs_n), .io3_oe(host_oe),
      .io3(host_io3), .cmd(cmd));
   flash_pin_reset_control #(.POWER_UP_CYCLES(100), .HOLD_CYCLES(HOLD), .PD_ENTRY_CYCLES(20),
      .PD_EXIT_CYCLES(40)) i_dut (.SYS_CLK(sys_clk), .SRST(srst), .LINK_CLK(link_clk), .CS_N(cs_n),
      .IO3_IN(io3_in), .CFG_ONE(cfg_one), .CFG_TWO(cfg_two), .POR_OK(por_ok), .CMD(cmd),
      .IO3_OUT(io3_out), .IO3_OE(io3_oe), .OUT_DISABLE(out_dis), .ABORT(abort), .REG_RELOAD(reload),
      .FULL_POR(full_por), .CMD_BLOCK(cmd_block), .SELECT_ALLOWED(sel_ok), .IN_POWERDOWN(in_pd),
      .STATE(state));
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   // pulses seen at the outputs
   always @(posedge sys_clk) begin
      if (abort === 1'b1) n_abort++;
      if (reload === 1'b1) n_reload++;
      if (full_por === 1'b1) n_por++;
      if (io3_oe === 1'b1 && io3_out === 1'b1) oe_seen++;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      if (n_errors == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic wait_state(input ctrl_state_t s, input int lim);
      k = 0;
      while (state !== s && k < lim) begin
         tick(1);
         k++;
      end
   endtask
   // reset pulse of w cycles, expected pulses from the model
   task automatic hw_reset(input int w, input bit taken);
      time t0;
      t0 = $time;
      i_host.pin_pulse(w);
      if (taken) begin
         e_abort++;
         if (por_ok) e_reload++;
         else e_por++;
         tick(20);
         check(sel_ok, 1'b0);
      end
      k = 0;
      while (cmd_block !== 1'b0 && k < 1000) begin
         tick(1);
         k++;
      end
      if (taken && por_ok) check((($time - t0) / 8) inside {[HOLD:HOLD + 8]}, 1'b1);
      tick(12);
      check(sel_ok, 1'b1);
      check(n_abort, e_abort);
      check(n_reload, e_reload);
      check(n_por, e_por);
   endtask
   initial begin
      #160000;
      n_errors++;
      test_done;
   end
   initial begin
      srst = 1'b1;
      cfg_one = 8'h00;
      cfg_two = 8'h00;
      por_ok = 1'b1;
      rnd = 16'h6cb7;
      tick(3);
      srst = 1'b0;
      tick(10);
      i_host.pin_pulse(30);
      wait_state(ST_STANDBY, 150);
      check(state, ST_STANDBY);
      tick(1);
      check(out_dis, 1'b0);
      check(n_abort, 0);
      tick(12);
      rnd = lfsr(rnd);
      hw_reset(28 + rnd[3:0], 1'b1);
      hw_reset(20, 1'b0);
      rnd = lfsr(rnd);
      cfg_one = {rnd[7:2], 1'b1, rnd[0]};
      cfg_two = {rnd[15:14], 1'b1, rnd[12:8]};
      i_host.set_cs(1'b0);
      hw_reset(40, 1'b0);
      k = oe_seen;
      i_host.send_cmd(cmd_t'(5'h02));
      tick(5);
      i_host.set_cs(1'b1);
      tick(20);
      check(oe_seen > k, 1'b1);
      rnd = lfsr(rnd);
      por_ok = rnd[4];
      hw_reset(30, 1'b1);
      cfg_one = {rnd[7:2], 1'b0, rnd[0]};
      por_ok = 1'b0;
      hw_reset(30, 1'b1);
      por_ok = 1'b1;
      i_host.send_cmd(cmd_t'(5'h10));
      tick(10);
      e_reload++;
      check(n_reload, e_reload);
      i_host.send_cmd(cmd_t'(5'h08));
      k = 0;
      while (in_pd !== 1'b1 && k < 35) begin
         tick(1);
         k++;
      end
      check(in_pd, 1'b1);
      i_host.send_cmd(cmd_t'(5'h10));
      tick(10);
      check(n_reload, e_reload);
      i_host.send_cmd(cmd_t'(5'h04));
      wait_state(ST_STANDBY, 55);
      check(state, ST_STANDBY);
      test_done;
   end
endmodule
`default_nettype wire
